// file: rtl/fan_pkg.sv
package fan_pkg;

  localparam int unsigned SYS_CLK_HZ = 25_000_000;

  // register map
  localparam logic [7:0] ADDR_FAN_ONE    = 8'h56;
  localparam logic [7:0] ADDR_FAN_TWO    = 8'h57;
  localparam logic [7:0] ADDR_CTRL       = 8'h58;
  localparam logic [7:0] ADDR_PRELOAD_A  = 8'h5A;
  localparam logic [7:0] ADDR_PRELOAD_B  = 8'h5B;
  localparam logic [7:0] ADDR_COUNT_A    = 8'h5C;
  localparam logic [7:0] ADDR_COUNT_B    = 8'h5D;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h60;
  localparam logic [7:0] ADDR_EVT_MASK   = 8'h61;
  localparam logic [7:0] ADDR_WAKE_EN    = 8'h62;
  localparam logic [7:0] ADDR_SYSMGMT_EN = 8'h63;

  // reset values
  localparam logic [7:0] RST_FAN      = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h50;
  localparam logic [7:0] RST_PRELOAD  = 8'h00;
  localparam logic [1:0] RST_EVT      = 2'h0;
  localparam logic [7:0] READ_NONE    = 8'h00;

  // fan output frequencies in millihertz, and steps per output period
  localparam int unsigned FOUT_KHZ_LO_MHZ = 15_625_000;
  localparam int unsigned FOUT_KHZ_HI_MHZ = 23_438_000;
  localparam int unsigned FOUT_HZ_LO_MHZ  = 40_000;
  localparam int unsigned FOUT_HZ_HI_MHZ  = 60_000;
  localparam int unsigned PWM_STEPS       = 64;
  localparam int unsigned MHZ_PER_HZ      = 1000;

  localparam int unsigned ACC_W = 26;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_CLK_HZ);
  localparam logic [ACC_W-1:0] INC_KHZ_LO = ACC_W'(FOUT_KHZ_LO_MHZ * PWM_STEPS / MHZ_PER_HZ);
  localparam logic [ACC_W-1:0] INC_KHZ_HI = ACC_W'(FOUT_KHZ_HI_MHZ * PWM_STEPS / MHZ_PER_HZ);
  localparam logic [ACC_W-1:0] INC_HZ_LO  = ACC_W'(FOUT_HZ_LO_MHZ * PWM_STEPS / MHZ_PER_HZ);
  localparam logic [ACC_W-1:0] INC_HZ_HI  = ACC_W'(FOUT_HZ_HI_MHZ * PWM_STEPS / MHZ_PER_HZ);

  // tachometer
  localparam logic [7:0] TACH_MAX  = 8'hFF;
  localparam logic [1:0] FAIL_MSBS = 2'h3;
  localparam logic [1:0] DIV_BY_1  = 2'h0;
  localparam logic [1:0] DIV_BY_2  = 2'h1;
  localparam logic [1:0] DIV_BY_4  = 2'h2;
  localparam logic [1:0] DIV_BY_8  = 2'h3;

  typedef struct packed {
    logic       clk_sel;
    logic [5:0] duty_code;
    logic       force_high;
  } per_channel_output_reg_t;

  typedef struct packed {
    logic [1:0] div_one;
    logic [1:0] div_two;
    logic       mult_two;
    logic       mult_one;
    logic       src_two;
    logic       src_one;
  } fan_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : fan_pkg

// file: rtl/fan_pwm_and_tach_monitor.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module fan_pwm_and_tach_monitor (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire fan_pkg::reg_req_t req,
  output logic            [7:0] rdata,
  input  wire logic             osc_32k,
  input  wire logic             speed_sense_in_a,
  input  wire logic             speed_sense_in_b,
  output logic                  fan_out_one,
  output logic                  fan_out_two,
  output logic                  irq,
  output logic                  wake_event,
  output logic                  sysmgmt_event
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  fan_pkg::per_channel_output_reg_t per_channel_output_reg [2];
  fan_pkg::fan_ctrl_t               ctrl;
  logic [7:0]                       preload [2];
  logic [1:0]                       evt_status;
  logic [1:0]                       evt_mask;
  logic [1:0]                       wake_enable_reg_one;
  logic [1:0]                       sysmgmt_enable_reg_five;

  logic [fan_pkg::ACC_W-1:0]        phase [2];
  logic [5:0]                       period_cnt [2];
  logic [1:0]                       fan_tick;
  logic                             osc_q;
  logic                             osc_tick;

  logic [7:0]                       count [2];
  logic [1:0]                       fail_pulse;
  logic [1:0]                       preload_wr;
  logic [7:0]                       next_preload [2];
  logic [1:0]                       src_sel;
  logic [1:0]                       mult_sel;
  logic [1:0]                       div_sel [2];
  logic                             status_rd;
  logic [fan_pkg::ACC_W-1:0]        inc [2];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // output step rate chosen jointly by the three bits
  function automatic logic [fan_pkg::ACC_W-1:0] step_inc(
    input logic src,
    input logic sel,
    input logic mult
  );
    logic [fan_pkg::ACC_W-1:0] base;
    base = '0;
    unique case ({src, sel})
      2'b00: base = fan_pkg::INC_KHZ_LO;
      2'b01: base = fan_pkg::INC_KHZ_HI;
      2'b10: base = fan_pkg::INC_HZ_LO;
      2'b11: base = fan_pkg::INC_HZ_HI;
    endcase
    step_inc = mult ? {base[fan_pkg::ACC_W-2:0], 1'b0} : base;
  endfunction : step_inc

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // per-channel views of the shared control register

  assign src_sel    = {ctrl.src_two, ctrl.src_one};
  assign mult_sel   = {ctrl.mult_two, ctrl.mult_one};
  assign div_sel[0] = ctrl.div_one;
  assign div_sel[1] = ctrl.div_two;

  assign preload_wr[0] = req.wr && hit(req.addr, fan_pkg::ADDR_PRELOAD_A);
  assign preload_wr[1] = req.wr && hit(req.addr, fan_pkg::ADDR_PRELOAD_B);
  assign status_rd     = req.rd && hit(req.addr, fan_pkg::ADDR_EVT_STATUS);

  // a preload write restarts the count from the value being written
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_preload[i] = preload_wr[i] ? req.wdata : preload[i];
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      inc[i] = step_inc(src_sel[i], per_channel_output_reg[i].clk_sel, mult_sel[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      per_channel_output_reg[0] <= fan_pkg::RST_FAN;
      per_channel_output_reg[1] <= fan_pkg::RST_FAN;
    end else if (req.wr) begin
      if (hit(req.addr, fan_pkg::ADDR_FAN_ONE)) per_channel_output_reg[0] <= req.wdata;
      if (hit(req.addr, fan_pkg::ADDR_FAN_TWO)) per_channel_output_reg[1] <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) ctrl <= fan_pkg::RST_CTRL;
    else if (req.wr && hit(req.addr, fan_pkg::ADDR_CTRL)) ctrl <= req.wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      preload[0] <= fan_pkg::RST_PRELOAD;
      preload[1] <= fan_pkg::RST_PRELOAD;
    end else begin
      preload[0] <= next_preload[0];
      preload[1] <= next_preload[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      evt_mask                <= fan_pkg::RST_EVT;
      wake_enable_reg_one     <= fan_pkg::RST_EVT;
      sysmgmt_enable_reg_five <= fan_pkg::RST_EVT;
    end else if (req.wr) begin
      if (hit(req.addr, fan_pkg::ADDR_EVT_MASK)) evt_mask <= req.wdata[1:0];
      if (hit(req.addr, fan_pkg::ADDR_WAKE_EN)) wake_enable_reg_one <= req.wdata[1:0];
      if (hit(req.addr, fan_pkg::ADDR_SYSMGMT_EN)) begin
        sysmgmt_enable_reg_five <= req.wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads: data stands the cycle after the strobe only

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= fan_pkg::READ_NONE;
    end else if (req.rd) begin
      unique case (req.addr)
        fan_pkg::ADDR_FAN_ONE:    rdata <= per_channel_output_reg[0];
        fan_pkg::ADDR_FAN_TWO:    rdata <= per_channel_output_reg[1];
        fan_pkg::ADDR_CTRL:       rdata <= ctrl;
        fan_pkg::ADDR_PRELOAD_A:  rdata <= preload[0];
        fan_pkg::ADDR_PRELOAD_B:  rdata <= preload[1];
        fan_pkg::ADDR_COUNT_A:    rdata <= count[0];
        fan_pkg::ADDR_COUNT_B:    rdata <= count[1];
        fan_pkg::ADDR_EVT_STATUS: rdata <= {6'h00, evt_status};
        fan_pkg::ADDR_EVT_MASK:   rdata <= {6'h00, evt_mask};
        fan_pkg::ADDR_WAKE_EN:    rdata <= {6'h00, wake_enable_reg_one};
        fan_pkg::ADDR_SYSMGMT_EN: rdata <= {6'h00, sysmgmt_enable_reg_five};
        default:                  rdata <= fan_pkg::READ_NONE;
      endcase
    end else begin
      rdata <= fan_pkg::READ_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output step generators

  // phase accumulator: exact average rate, jitter of one system clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase[0] <= '0;
      phase[1] <= '0;
      fan_tick <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (phase[i] + inc[i] >= fan_pkg::ACC_MOD) begin
          phase[i]    <= phase[i] + inc[i] - fan_pkg::ACC_MOD;
          fan_tick[i] <= 1'b1;
        end else begin
          phase[i]    <= phase[i] + inc[i];
          fan_tick[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      period_cnt[0] <= 6'h00;
      period_cnt[1] <= 6'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fan_tick[i]) period_cnt[i] <= period_cnt[i] + 6'h01;
      end
    end
  end

  // force-high beats the duty code; code zero never passes the compare
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fan_out_one <= 1'b0;
      fan_out_two <= 1'b0;
    end else begin
      fan_out_one <= per_channel_output_reg[0].force_high ||
                     (period_cnt[0] < per_channel_output_reg[0].duty_code);
      fan_out_two <= per_channel_output_reg[1].force_high ||
                     (period_cnt[1] < per_channel_output_reg[1].duty_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tachometer channels

  always_ff @(posedge sys_clk) begin
    if (sys_rst) osc_q <= 1'b0;
    else osc_q <= osc_32k;
  end

  assign osc_tick = osc_32k & ~osc_q;

  fan_tach_channel tach_a (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .osc_tick   (osc_tick),
    .div_code   (div_sel[0]),
    .preload    (next_preload[0]),
    .preload_wr (preload_wr[0]),
    .sense_in   (speed_sense_in_a),
    .count      (count[0]),
    .fail_pulse (fail_pulse[0])
  );

  fan_tach_channel tach_b (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .osc_tick   (osc_tick),
    .div_code   (div_sel[1]),
    .preload    (next_preload[1]),
    .preload_wr (preload_wr[1]),
    .sense_in   (speed_sense_in_b),
    .count      (count[1]),
    .fail_pulse (fail_pulse[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt

  // a new failure in the clearing read's cycle stays set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) evt_status <= fan_pkg::RST_EVT;
    else evt_status <= (status_rd ? 2'h0 : evt_status) | fail_pulse;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq           <= 1'b0;
      wake_event    <= 1'b0;
      sysmgmt_event <= 1'b0;
    end else begin
      irq           <= |(evt_status & evt_mask);
      wake_event    <= |(evt_status & wake_enable_reg_one);
      sysmgmt_event <= |(evt_status & sysmgmt_enable_reg_five);
    end
  end

endmodule : fan_pwm_and_tach_monitor

// file: rtl/fan_tach_channel.sv
`timescale 1ns/1ns
module fan_tach_channel (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       osc_tick,
  input  wire logic [1:0] div_code,
  input  wire logic [7:0] preload,
  input  wire logic       preload_wr,
  input  wire logic       sense_in,
  output logic      [7:0] count,
  output logic            fail_pulse
);

  logic       sense_q;
  logic [2:0] prescale;
  logic       above_q;
  logic       restart;
  logic       count_tick;
  logic       above;

  function automatic logic [2:0] div_last(input logic [1:0] code);
    unique case (code)
      fan_pkg::DIV_BY_1: div_last = 3'h0;
      fan_pkg::DIV_BY_2: div_last = 3'h1;
      fan_pkg::DIV_BY_4: div_last = 3'h3;
      fan_pkg::DIV_BY_8: div_last = 3'h7;
    endcase
  endfunction : div_last

  assign restart    = (sense_in & ~sense_q) | preload_wr;
  assign count_tick = osc_tick && (prescale >= div_last(div_code));
  assign above      = (count[7:6] == fan_pkg::FAIL_MSBS);
  assign fail_pulse = above & ~above_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) sense_q <= 1'b0;
    else sense_q <= sense_in;
  end

  // prescaler restarts with the counter so each period sees whole divided ticks
  always_ff @(posedge sys_clk) begin
    if (sys_rst || restart) prescale <= 3'h0;
    else if (count_tick) prescale <= 3'h0;
    else if (osc_tick) prescale <= prescale + 3'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) count <= fan_pkg::RST_PRELOAD;
    else if (restart) count <= preload;
    else if (count_tick && count != fan_pkg::TACH_MAX) count <= count + 8'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) above_q <= 1'b0;
    else above_q <= above;
  end

endmodule : fan_tach_channel

// file: tb/fan_chk.sv
`timescale 1ns/1ns
module fan_chk (
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire fan_pkg::reg_req_t req,
  input wire logic        [7:0] rdata,
  input wire logic              fan_out_one,
  input wire logic              fan_out_two,
  input wire logic              irq,
  input wire logic              wake_event,
  input wire logic              sysmgmt_event
);
  logic [7:0] fan_a, fan_b, pre_a, pre_b;
  logic [1:0] mask, wake_en, smg_en;
  // shadows of what software wrote, so outputs can be tied to settings
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {fan_a, fan_b, pre_a, pre_b} <= '0;
      {mask, wake_en, smg_en}      <= '0;
    end else if (req.wr) begin
      case (req.addr)
        fan_pkg::ADDR_FAN_ONE:    fan_a   <= req.wdata;
        fan_pkg::ADDR_FAN_TWO:    fan_b   <= req.wdata;
        fan_pkg::ADDR_PRELOAD_A:  pre_a   <= req.wdata;
        fan_pkg::ADDR_PRELOAD_B:  pre_b   <= req.wdata;
        fan_pkg::ADDR_EVT_MASK:   mask    <= req.wdata[1:0];
        fan_pkg::ADDR_WAKE_EN:    wake_en <= req.wdata[1:0];
        fan_pkg::ADDR_SYSMGMT_EN: smg_en  <= req.wdata[1:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_low: assert property ($past(sys_rst) |-> !fan_out_one && !fan_out_two)
    else $error("fan outputs not low after reset");
  a_force_one: assert property (fan_a[0] && $past(fan_a[0]) |-> fan_out_one)
    else $error("fan one not forced high");
  a_force_two: assert property (fan_b[0] && $past(fan_b[0]) |-> fan_out_two)
    else $error("fan two not forced high");
  a_zero_low: assert property (fan_a[6:0] == 7'h00 && $past(fan_a[6:0]) == 7'h00
    |-> !fan_out_one)
    else $error("zero duty fan one not low");
  a_irq_masked: assert property (mask == 2'h0 && $past(mask) == 2'h0 |-> !irq)
    else $error("irq high with all masked");
  a_wake_gate: assert property (wake_en == 2'h0 && $past(wake_en) == 2'h0 |-> !wake_event)
    else $error("wake event without enable");
  a_smg_gate: assert property (smg_en == 2'h0 && $past(smg_en) == 2'h0 |-> !sysmgmt_event)
    else $error("sysmgmt event without enable");
  a_floor_a: assert property ($past(req.rd && req.addr == fan_pkg::ADDR_COUNT_A)
    |-> rdata >= $past(pre_a))
    else $error("count a below preload");
  a_floor_b: assert property ($past(req.rd && req.addr == fan_pkg::ADDR_COUNT_B)
    |-> rdata >= $past(pre_b))
    else $error("count b below preload");
  c_pwm_rise: cover property (fan_out_one && !$past(fan_out_one));
  c_irq: cover property (irq);
  c_wake: cover property (wake_event);
  c_smg: cover property (sysmgmt_event);
endmodule : fan_chk
bind fan_pwm_and_tach_monitor fan_chk u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
  .fan_out_one(fan_out_one), .fan_out_two(fan_out_two), .irq(irq),
  .wake_event(wake_event), .sysmgmt_event(sysmgmt_event)
);

// file: tb/fan_tach_model.sv
`timescale 1ns/1ns
module fan_tach_model (
  input  wire logic sys_clk,
  input  int        half_period,
  output logic      tach
);
  int cnt = 0;
  initial tach = 1'b0;
  // a stalled fan parks its tach line low and gives no edges at all
  always @(posedge sys_clk) begin
    if (half_period == 0) begin
      cnt  <= 0;
      tach <= 1'b0;
    end else if (cnt >= half_period - 1) begin
      cnt  <= 0;
      tach <= ~tach;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : fan_tach_model

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              osc_32k = 1'b0;
  fan_pkg::reg_req_t req     = '0;
  logic        [7:0] rdata, got;
  logic              fan_out_one, fan_out_two, irq, wake_event, sysmgmt_event;
  logic              sense_a, sense_b, cur, prev;
  int                half_a = 0, half_b = 200, hi, rise;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                osc_div   = 0;
  always #20 sys_clk = ~sys_clk;
  // oscillator sped up to eight clocks a period so threshold runs stay short
  always @(posedge sys_clk) begin
    if (osc_div == 3) begin
      osc_div <= 0;
      osc_32k <= ~osc_32k;
    end else begin
      osc_div <= osc_div + 1;
    end
  end
  fan_pwm_and_tach_monitor u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .osc_32k(osc_32k), .speed_sense_in_a(sense_a),
    .speed_sense_in_b(sense_b), .fan_out_one(fan_out_one), .fan_out_two(fan_out_two),
    .irq(irq), .wake_event(wake_event), .sysmgmt_event(sysmgmt_event));
  fan_tach_model u_fan_a (.sys_clk(sys_clk), .half_period(half_a), .tach(sense_a));
  fan_tach_model u_fan_b (.sys_clk(sys_clk), .half_period(half_b), .tach(sense_b));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string name, input logic [15:0] lo, input logic [15:0] up,
                     input logic [15:0] seen);
    cmp_count++;
    if ((seen >= lo && seen <= up) !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, up, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd
  task automatic chk_rd(input string name, input logic [7:0] a, input logic [7:0] lo,
                        input logic [7:0] up);
    rd(a);
    chk(name, 16'(lo), 16'(up), 16'(got));
  endtask : chk_rd
  task automatic measure(input bit two, input int n);
    hi = 0;
    rise = 0;
    prev = two ? fan_out_two : fan_out_one;
    repeat (n) begin
      @(posedge sys_clk);
      #1 cur = two ? fan_out_two : fan_out_one;
      if (cur === 1'b1) hi++;
      if (cur === 1'b1 && prev === 1'b0) rise++;
      prev = cur;
    end
  endtask : measure
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("fan one out", 16'h0000, 16'h0000, 16'(fan_out_one));
    chk("fan two out", 16'h0000, 16'h0000, 16'(fan_out_two));
    chk("irq at reset", 16'h0000, 16'h0000, 16'(irq));
    chk_rd("fan one reg", fan_pkg::ADDR_FAN_ONE, 8'h00, 8'h00);
    chk_rd("ctrl reg", fan_pkg::ADDR_CTRL, 8'h50, 8'h50);
    chk_rd("unmapped", 8'h70, 8'h00, 8'h00);
  endtask : t_reset
  task automatic t_pwm;
    logic [5:0] dl[3];
    dl = '{6'h00, 6'h01, 6'h3F};
    for (int i = 0; i < 3; i++) begin
      wr(fan_pkg::ADDR_FAN_ONE, {1'b0, dl[i], 1'b0});
      repeat (4) @(posedge sys_clk);
      measure(1'b0, 1600);
      chk("fan one high", 16'(dl[i]) * 16'h0019, 16'(dl[i]) * 16'h0019, 16'(hi));
    end
    wr(fan_pkg::ADDR_FAN_ONE, 8'h01);
    repeat (4) @(posedge sys_clk);
    measure(1'b0, 1600);
    chk("fan one forced", 16'h0640, 16'h0640, 16'(hi));
    wr(fan_pkg::ADDR_FAN_ONE, 8'h00);
  endtask : t_pwm
  task automatic t_clock;
    wr(fan_pkg::ADDR_CTRL, 8'h58);
    wr(fan_pkg::ADDR_FAN_TWO, 8'h40);
    repeat (4) @(posedge sys_clk);
    measure(1'b1, 1600);
    chk("doubled rises", 16'h0002, 16'h0002, 16'(rise));
    chk("doubled high", 16'h0320, 16'h0320, 16'(hi));
    wr(fan_pkg::ADDR_CTRL, 8'h50);
    wr(fan_pkg::ADDR_FAN_TWO, 8'hC0);
    measure(1'b1, 6300);
    chk("select hi rises", 16'h0005, 16'h0006, 16'(rise));
  endtask : t_clock
  task automatic t_events;
    wr(fan_pkg::ADDR_WAKE_EN, 8'h01);
    chk_rd("early status", fan_pkg::ADDR_EVT_STATUS, 8'h01, 8'h01);
    wr(fan_pkg::ADDR_PRELOAD_A, 8'h20);
    repeat (1500) @(posedge sys_clk);
    chk_rd("restart count", fan_pkg::ADDR_COUNT_A, 8'h20, 8'h7F);
    repeat (1700) @(posedge sys_clk);
    chk("wake", 16'h0001, 16'h0001, 16'(wake_event));
    chk("irq masked", 16'h0000, 16'h0000, 16'(irq));
    wr(fan_pkg::ADDR_EVT_MASK, 8'h01);
    wr(fan_pkg::ADDR_SYSMGMT_EN, 8'h01);
    repeat (3) @(posedge sys_clk);
    chk("irq", 16'h0001, 16'h0001, 16'(irq));
    chk("sysmgmt", 16'h0001, 16'h0001, 16'(sysmgmt_event));
    chk_rd("status", fan_pkg::ADDR_EVT_STATUS, 8'h01, 8'h01);
    chk_rd("status cleared", fan_pkg::ADDR_EVT_STATUS, 8'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk("irq cleared", 16'h0000, 16'h0000, 16'(irq));
    repeat (1500) @(posedge sys_clk);
    chk_rd("saturated", fan_pkg::ADDR_COUNT_A, 8'hFF, 8'hFF);
    chk_rd("fan b count", fan_pkg::ADDR_COUNT_B, 8'h00, 8'h1A);
    half_a = 200;
    repeat (1000) @(posedge sys_clk);
    chk_rd("running count", fan_pkg::ADDR_COUNT_A, 8'h20, 8'h3A);
    half_a = 0;
  endtask : t_events
  task automatic t_divisor;
    for (int d = 0; d < 4; d++) begin
      wr(fan_pkg::ADDR_CTRL, {2'(d), 6'h10});
      chk_rd("ctrl readback", fan_pkg::ADDR_CTRL, {2'(d), 6'h10}, {2'(d), 6'h10});
      @(negedge osc_32k);
      wr(fan_pkg::ADDR_PRELOAD_A, 8'h00);
      repeat (16) @(posedge osc_32k);
      repeat (2) @(posedge sys_clk);
      chk_rd("divided count", fan_pkg::ADDR_COUNT_A, 8'h10 >> d, 8'h10 >> d);
    end
  endtask : t_divisor
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_pwm();
    t_clock();
    t_events();
    t_divisor();
    end_sim();
  end
endmodule : testbench
